// [src/bmc_pkg.sv]
package bmc_pkg;

  // ------------------------------------------------------------
  // management register map
  // ------------------------------------------------------------
  localparam logic [4:0] BMC_CTRL_ADDR = 5'h00;
  localparam int BMC_DATA_W = 16;

  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int BMC_SOFT_RESET_BIT = 15;
  localparam int BMC_LOOPBACK_BIT = 14;
  localparam int BMC_RATE_BIT = 13;
  localparam int BMC_AN_ENABLE_BIT = 12;
  localparam int BMC_LOW_POWER_BIT = 11;
  localparam int BMC_ISOLATE_BIT = 10;
  localparam int BMC_AN_RESTART_BIT = 9;
  localparam int BMC_DUPLEX_BIT = 8;
  localparam int BMC_COL_TEST_BIT = 7;
  localparam int BMC_RSVD_MSB = 6;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic BMC_LOOPBACK_RST = 1'b0;
  localparam logic BMC_RATE_RST = 1'b1;
  localparam logic BMC_AN_ENABLE_RST = 1'b1;
  localparam logic BMC_LOW_POWER_RST = 1'b0;
  localparam logic BMC_ISOLATE_RST = 1'b0;
  localparam logic BMC_AN_RESTART_RST = 1'b0;
  localparam logic BMC_DUPLEX_RST = 1'b0;
  localparam logic BMC_COL_TEST_RST = 1'b0;
  localparam logic [6:0] BMC_RSVD_VALUE = 7'h00;
  localparam logic [4:0] BMC_ISO_PHY_ADDR = 5'h00;

  // ------------------------------------------------------------
  // collision test timing, worst case is the 100 Mb/s bit time
  // ------------------------------------------------------------
  localparam int BMC_CLK_PERIOD_PS = 25000;
  localparam int BMC_BIT_TIME_PS = 10000;
  localparam int BMC_COL_ON_MAX_BITS = 512;
  localparam int BMC_COL_OFF_MAX_BITS = 4;
  localparam int BMC_COL_ON_MAX_RAW =
    (BMC_COL_ON_MAX_BITS * BMC_BIT_TIME_PS) / BMC_CLK_PERIOD_PS;
  localparam int BMC_COL_OFF_MAX_RAW =
    (BMC_COL_OFF_MAX_BITS * BMC_BIT_TIME_PS) / BMC_CLK_PERIOD_PS;
  localparam int BMC_COL_ON_MAX_CYC = (BMC_COL_ON_MAX_RAW < 1) ? 1 : BMC_COL_ON_MAX_RAW;
  localparam int BMC_COL_OFF_MAX_CYC = (BMC_COL_OFF_MAX_RAW < 1) ? 1 : BMC_COL_OFF_MAX_RAW;
  localparam int BMC_COL_ON_DEF_CYC = 1;
  localparam int BMC_COL_CNT_W = 8;

endpackage : bmc_pkg

// [src/bmc_col_stage.sv]
`timescale 1ns/1ps
`default_nettype none

module bmc_col_stage
  import bmc_pkg::*;
#(
  parameter int unsigned COL_ON_CYC = BMC_COL_ON_DEF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // control
  input wire logic col_test_en,
  input wire logic low_power,
  input wire logic isolate,
  input wire logic loopback,
  // sources
  input wire logic mii_tx_en,
  input wire logic line_col,
  // result
  output logic mac_col
);

  logic [BMC_COL_CNT_W-1:0] on_cnt_reg;
  logic col_reg;
  logic test_active;

  // transmit enable is ignored while isolated or powered down
  assign test_active = col_test_en && mii_tx_en && !isolate && !low_power;

  // count cycles of asserted transmit enable, saturating at the on delay
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      on_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!test_active) begin
        on_cnt_reg <= '0;
      end else if (on_cnt_reg < COL_ON_CYC[BMC_COL_CNT_W-1:0]) begin
        on_cnt_reg <= on_cnt_reg + 8'h01;
      end
    end
  end

  // one flop: drop follows transmit enable by one cycle, well inside 4 bit times
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      col_reg <= 1'b0;
    end else if (clk_en) begin
      if (low_power || isolate) begin
        col_reg <= 1'b0;
      end else if (col_test_en) begin
        col_reg <= test_active && (on_cnt_reg + 8'h01 >= COL_ON_CYC[BMC_COL_CNT_W-1:0]); // R15 R16
      end else begin
        col_reg <= loopback ? 1'b0 : line_col; // R14 R19
      end
    end
  end

  assign mac_col = col_reg;

endmodule : bmc_col_stage

`default_nettype wire

// [src/bmc_basic_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: hardware mode takes autoneg from select pin
// R2: software, autoneg off: rate, duplex bits rule
// R3: software, autoneg on: rate, duplex bits ignored
// R4: low power: outputs low, pair tri-stated
// R5: low power entry clears latching status
// R6: reset loads every bit default; the isolate bit takes its default on the first enabled edge after release
// R7: isolate floats MII outputs, ignores inputs
// R8: isolate defaults one at address zero
// R9: restart write ignored while autoneg off
// R10: restart kicks negotiation, clears when begun
// R11: hardware mode duplex from duplex pin
// R12: duplex bit half/full, else negotiation result
// R13: loopback makes duplex bit ineffective
// R14: collision test off: COL ignores TX_EN
// R15: test COL on within 512, off 4
// R16: collision test works in loopback too
// R17: reserved bits six to zero read zero
// R18: agent writes defaults into reserved bits
// R19: loopback returns MII transmit to receive
// R20: sixteen-bit control at management address zero
module bmc_basic_ctrl
  import bmc_pkg::*;
#(
  parameter int unsigned COL_ON_CYC = BMC_COL_ON_DEF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // straps
  input wire logic strap_mode_select_pin,
  input wire logic autoneg_select_pin,
  input wire logic duplex_select_pin,
  input wire logic rate_select_pin,
  input wire logic [4:0] phy_addr,
  // management register port
  input wire logic [4:0] mgmt_reg_addr,
  input wire logic mgmt_wr_en,
  input wire logic [15:0] mgmt_wr_data,
  input wire logic mgmt_rd_en,
  output logic [15:0] mgmt_rd_data,
  output logic mgmt_rd_valid,
  // auto-negotiation engine
  input wire logic an_started,
  input wire logic an_duplex_result,
  input wire logic an_rate_result,
  output logic an_enable,
  output logic an_restart,
  // mode results
  output logic eff_duplex_full,
  output logic eff_rate_100,
  output logic low_power,
  output logic latch_high_status_clear,
  output logic latch_low_status_clear,
  // MAC transmit side inputs
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  // MAC receive side outputs, enables low while driving
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_col,
  output logic mac_out_oe_n,
  // line side
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  input wire logic line_rx_er,
  input wire logic line_crs,
  input wire logic line_col,
  output logic [3:0] line_txd,
  output logic line_tx_en,
  output logic line_tx_er,
  output logic tx_pair_tristate,
  output logic line_rx_enable
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic bmc_is_ctrl(input logic [4:0] addr);
    bmc_is_ctrl = (addr == BMC_CTRL_ADDR); // R20
  endfunction : bmc_is_ctrl

  // ------------------------------------------------------------
  // control register state
  // ------------------------------------------------------------
  logic loopback_reg;
  logic rate_reg;
  logic an_en_reg;
  logic low_power_reg;
  logic isolate_reg;
  logic restart_reg;
  logic duplex_reg;
  logic col_test_reg;
  logic iso_init_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;
  logic an_restart_reg;
  logic lh_clear_reg;
  logic ll_clear_reg;
  logic an_enable_reg;
  logic duplex_out_reg;
  logic rate_out_reg;

  logic sw_mode;
  logic wr_hit;
  logic an_eff;
  logic an_after_wr;
  logic restart_req;
  logic duplex_eff;
  logic rate_eff;
  logic [15:0] ctrl_view;

  // strap high selects software mode
  assign sw_mode = strap_mode_select_pin;
  assign wr_hit = mgmt_wr_en && bmc_is_ctrl(mgmt_reg_addr);

  // autoneg decision: pin in hardware mode, register bit otherwise
  assign an_eff = sw_mode ? an_en_reg : autoneg_select_pin; // R1 R3
  assign an_after_wr = sw_mode ? mgmt_wr_data[BMC_AN_ENABLE_BIT] : autoneg_select_pin;

  // a restart write only counts when autoneg is on after that write
  assign restart_req = wr_hit && mgmt_wr_data[BMC_AN_RESTART_BIT] && an_after_wr; // R9

  // ------------------------------------------------------------
  // effective duplex and rate
  // ------------------------------------------------------------
  always_comb begin
    if (!sw_mode) begin
      duplex_eff = duplex_select_pin; // R11
      rate_eff = rate_select_pin;
    end else if (an_eff) begin
      duplex_eff = an_duplex_result; // R3 R12
      rate_eff = an_rate_result;
    end else begin
      // loopback path is internal, so the duplex bit is bypassed there
      duplex_eff = loopback_reg ? 1'b1 : duplex_reg; // R2 R12 R13
      rate_eff = rate_reg; // R2
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // isolate default needs the address, which cannot feed an async reset;
  // it is loaded on the first enabled edge after release instead
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loopback_reg <= BMC_LOOPBACK_RST; // R6
      rate_reg <= BMC_RATE_RST;
      an_en_reg <= BMC_AN_ENABLE_RST;
      low_power_reg <= BMC_LOW_POWER_RST;
      isolate_reg <= BMC_ISOLATE_RST;
      duplex_reg <= BMC_DUPLEX_RST;
      col_test_reg <= BMC_COL_TEST_RST;
      iso_init_reg <= 1'b1;
    end else if (clk_en) begin
      if (iso_init_reg) begin
        isolate_reg <= (phy_addr == BMC_ISO_PHY_ADDR); // R8
        iso_init_reg <= 1'b0;
      end
      // a write in the same cycle as the default load wins
      if (wr_hit) begin
        loopback_reg <= mgmt_wr_data[BMC_LOOPBACK_BIT];
        rate_reg <= mgmt_wr_data[BMC_RATE_BIT];
        an_en_reg <= mgmt_wr_data[BMC_AN_ENABLE_BIT];
        low_power_reg <= mgmt_wr_data[BMC_LOW_POWER_BIT];
        isolate_reg <= mgmt_wr_data[BMC_ISOLATE_BIT];
        duplex_reg <= mgmt_wr_data[BMC_DUPLEX_BIT];
        col_test_reg <= mgmt_wr_data[BMC_COL_TEST_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // self-clearing restart
  // ------------------------------------------------------------
  // a new request in the cycle the engine reports its start is kept
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= BMC_AN_RESTART_RST;
      an_restart_reg <= 1'b0;
    end else if (clk_en) begin
      an_restart_reg <= restart_req; // R10
      if (restart_req) begin
        restart_reg <= 1'b1; // R9 R10
      end else if (an_started) begin
        restart_reg <= 1'b0; // R10
      end
    end
  end

  // ------------------------------------------------------------
  // low-power entry: latching status goes back to defaults
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lh_clear_reg <= 1'b0;
      ll_clear_reg <= 1'b0;
    end else if (clk_en) begin
      lh_clear_reg <= wr_hit && mgmt_wr_data[BMC_LOW_POWER_BIT] && !low_power_reg; // R5
      ll_clear_reg <= wr_hit && mgmt_wr_data[BMC_LOW_POWER_BIT] && !low_power_reg; // R5
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[BMC_LOOPBACK_BIT] = loopback_reg;
    ctrl_view[BMC_RATE_BIT] = rate_reg;
    ctrl_view[BMC_AN_ENABLE_BIT] = an_en_reg;
    ctrl_view[BMC_LOW_POWER_BIT] = low_power_reg;
    ctrl_view[BMC_ISOLATE_BIT] = isolate_reg;
    ctrl_view[BMC_AN_RESTART_BIT] = restart_reg;
    ctrl_view[BMC_DUPLEX_BIT] = duplex_reg;
    ctrl_view[BMC_COL_TEST_BIT] = col_test_reg;
    ctrl_view[BMC_RSVD_MSB:0] = BMC_RSVD_VALUE; // R17 R18
  end

  // other addresses belong to neighbouring blocks and read zero here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rd_valid_reg <= mgmt_rd_en;
      if (mgmt_rd_en) begin
        rd_data_reg <= bmc_is_ctrl(mgmt_reg_addr) ? ctrl_view : 16'h0000; // R17 R20
      end
    end
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      an_enable_reg <= BMC_AN_ENABLE_RST;
      duplex_out_reg <= BMC_DUPLEX_RST;
      rate_out_reg <= BMC_RATE_RST;
    end else if (clk_en) begin
      an_enable_reg <= an_eff && !low_power_reg; // R1 R2 R3 R4
      duplex_out_reg <= duplex_eff; // R11 R12
      rate_out_reg <= rate_eff;
    end
  end

  // ------------------------------------------------------------
  // MAC receive side
  // ------------------------------------------------------------
  // low power outranks isolate: pins are driven low, not floated
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mac_rxd <= 4'h0;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
      mac_crs <= 1'b0;
      mac_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      if (low_power_reg) begin
        mac_rxd <= 4'h0; // R4
        mac_rx_dv <= 1'b0;
        mac_rx_er <= 1'b0;
        mac_crs <= 1'b0;
        mac_out_oe_n <= 1'b0;
      end else if (isolate_reg) begin
        mac_rxd <= 4'h0; // R7
        mac_rx_dv <= 1'b0;
        mac_rx_er <= 1'b0;
        mac_crs <= 1'b0;
        mac_out_oe_n <= 1'b1;
      end else if (loopback_reg) begin
        mac_rxd <= mii_txd; // R19
        mac_rx_dv <= mii_tx_en;
        mac_rx_er <= mii_tx_er;
        mac_crs <= mii_tx_en;
        mac_out_oe_n <= 1'b0;
      end else begin
        mac_rxd <= line_rxd;
        mac_rx_dv <= line_rx_dv;
        mac_rx_er <= line_rx_er;
        mac_crs <= line_crs;
        mac_out_oe_n <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // line side: transmitter and receiver gating
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_txd <= 4'h0;
      line_tx_en <= 1'b0;
      line_tx_er <= 1'b0;
      tx_pair_tristate <= 1'b0;
      line_rx_enable <= 1'b1;
    end else if (clk_en) begin
      if (low_power_reg || isolate_reg || loopback_reg) begin
        line_txd <= 4'h0; // R4 R7 R19
        line_tx_en <= 1'b0;
        line_tx_er <= 1'b0;
      end else begin
        line_txd <= mii_txd;
        line_tx_en <= mii_tx_en;
        line_tx_er <= mii_tx_er;
      end
      tx_pair_tristate <= low_power_reg || loopback_reg; // R4 R19
      line_rx_enable <= !(low_power_reg || loopback_reg); // R4 R19
    end
  end

  // ------------------------------------------------------------
  // collision output stage
  // ------------------------------------------------------------
  bmc_col_stage #(
    .COL_ON_CYC(COL_ON_CYC)
  ) u_col_stage (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .col_test_en(col_test_reg),
    .low_power(low_power_reg),
    .isolate(isolate_reg),
    .loopback(loopback_reg),
    .mii_tx_en(mii_tx_en),
    .line_col(line_col),
    .mac_col(mac_col)
  );

  // ------------------------------------------------------------
  // output wiring from flops
  // ------------------------------------------------------------
  assign mgmt_rd_data = rd_data_reg;
  assign mgmt_rd_valid = rd_valid_reg;
  assign an_enable = an_enable_reg;
  assign an_restart = an_restart_reg;
  assign eff_duplex_full = duplex_out_reg;
  assign eff_rate_100 = rate_out_reg;
  assign low_power = low_power_reg;
  assign latch_high_status_clear = lh_clear_reg;
  assign latch_low_status_clear = ll_clear_reg;

endmodule : bmc_basic_ctrl

`default_nettype wire

// [verif/bmc_an_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// negotiation engine stand-in: reports a start after a delay
// ------------------------------------------------------------
module bmc_an_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // restart request and chosen delay, zero answers promptly
  input wire logic an_restart,
  input wire logic [3:0] start_delay,
  // start report
  output logic an_started
);
  logic [4:0] cnt_reg;

  // a fresh restart reloads the wait, so a late start is never lost
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 5'h00;
      an_started <= 1'b0;
    end else begin
      an_started <= (cnt_reg == 5'h01);
      if (an_restart) begin
        cnt_reg <= {1'b0, start_delay} + 5'h01;
      end else if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule : bmc_an_partner

`default_nettype wire

// [verif/bmc_basic_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module bmc_basic_ctrl_assertions
  import bmc_pkg::*;
#(
  parameter int unsigned COL_ON_CYC = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // straps
  input wire logic strap_mode_select_pin,
  input wire logic autoneg_select_pin,
  input wire logic duplex_select_pin,
  input wire logic [4:0] phy_addr,
  // register port
  input wire logic [4:0] mgmt_reg_addr,
  input wire logic mgmt_wr_en,
  input wire logic [15:0] mgmt_wr_data,
  input wire logic mgmt_rd_en,
  input wire logic [15:0] mgmt_rd_data,
  input wire logic mgmt_rd_valid,
  // mode results
  input wire logic an_restart,
  input wire logic an_enable,
  input wire logic eff_duplex_full,
  input wire logic low_power,
  input wire logic latch_high_status_clear,
  // data side
  input wire logic mii_tx_en,
  input wire logic line_col,
  input wire logic [3:0] mac_rxd,
  input wire logic mac_col,
  input wire logic mac_out_oe_n,
  input wire logic line_tx_en,
  input wire logic tx_pair_tristate
);
  localparam int COL_LIM = COL_ON_CYC + 1;
  logic [15:0] ctrl_q;
  logic first_q;
  logic wr0;

  // ------------------------------------------------------------
  // shadow of the control word, isolate loads on first edge
  // ------------------------------------------------------------
  assign wr0 = clk_en && mgmt_wr_en && (mgmt_reg_addr == BMC_CTRL_ADDR);

  // a write at the first edge wins over the address-based load
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 16'h3000;
      first_q <= 1'b1;
    end else if (clk_en) begin
      first_q <= 1'b0;
      if (wr0) begin
        ctrl_q <= mgmt_wr_data;
      end else if (first_q) begin
        ctrl_q[10] <= (phy_addr == 5'h00);
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_rd_unmapped_zero: assert property (clk_en && mgmt_rd_en && mgmt_reg_addr != BMC_CTRL_ADDR
    |=> mgmt_rd_valid && mgmt_rd_data == 16'h0000) else $error("unmapped read not zero");
  a_rsvd_read_zero: assert property (mgmt_rd_valid |-> mgmt_rd_data[6:0] == 7'h00)
    else $error("reserved bits read nonzero");
  a_restart_blocked: assert property (wr0 && strap_mode_select_pin && mgmt_wr_data[9]
    && !mgmt_wr_data[12] |=> !an_restart) else $error("restart taken while autoneg off");
  a_restart_taken: assert property (wr0 && strap_mode_select_pin && mgmt_wr_data[9]
    && mgmt_wr_data[12] && !mgmt_wr_data[11] && !low_power |=> an_restart)
    else $error("restart write lost");
  a_lp_latch_clear: assert property (wr0 && mgmt_wr_data[11] && !low_power
    |=> latch_high_status_clear) else $error("latching status not cleared");
  a_lp_quiet_outs: assert property (low_power [*2] |-> mac_rxd == 4'h0 && !mac_col
    && !mac_out_oe_n && tx_pair_tristate) else $error("low power outputs wrong");
  a_iso_float_outs: assert property ((ctrl_q[10] && !ctrl_q[11]) [*2]
    |-> mac_out_oe_n && !line_tx_en) else $error("isolate not floating");
  a_col_test_rise: assert property (ctrl_q[7] && !ctrl_q[11] && !ctrl_q[10] && clk_en
    && $rose(mii_tx_en) |-> ##[1:COL_LIM] mac_col) else $error("test collision late");
  a_col_test_fall: assert property (ctrl_q[7] && !ctrl_q[11] && !ctrl_q[10] && clk_en
    && $fell(mii_tx_en) |=> !mac_col) else $error("test collision held");
  a_col_line_track: assert property (!ctrl_q[7] && !ctrl_q[14] && !ctrl_q[11] && !ctrl_q[10]
    && clk_en |=> mac_col == $past(line_col)) else $error("collision follows wrong source");
  a_duplex_sw_bit: assert property (strap_mode_select_pin && !ctrl_q[12] && !ctrl_q[14]
    && !ctrl_q[11] && clk_en |=> eff_duplex_full == $past(ctrl_q[8]))
    else $error("duplex bit not applied");
  a_hw_pin_modes: assert property (!strap_mode_select_pin && !low_power && clk_en |=>
    an_enable == $past(autoneg_select_pin) && eff_duplex_full == $past(duplex_select_pin))
    else $error("hardware mode pins ignored");

  c_restart: cover property (an_restart);
  c_col_test: cover property (ctrl_q[7] && mac_col);
  c_low_power: cover property (low_power [*2]);
endmodule : bmc_basic_ctrl_assertions

bind bmc_basic_ctrl bmc_basic_ctrl_assertions #(.COL_ON_CYC(COL_ON_CYC)) u_chk (.*);

`default_nettype wire

// [verif/bmc_basic_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module bmc_basic_ctrl_tb;
  import bmc_pkg::*;
  localparam int COL_CYC = 3;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, strap_mode_select_pin = 1'b1;
  logic autoneg_select_pin = 1'b0, duplex_select_pin = 1'b0, rate_select_pin = 1'b0;
  logic mgmt_wr_en = 1'b0, mgmt_rd_en = 1'b0, an_duplex_result = 1'b1, an_rate_result = 1'b1;
  logic mii_tx_en = 1'b0, mii_tx_er = 1'b0, line_rx_dv = 1'b0, line_rx_er = 1'b0;
  logic line_crs = 1'b0, line_col = 1'b0;
  logic [4:0] phy_addr = 5'h01, mgmt_reg_addr = 5'h00;
  logic [15:0] mgmt_wr_data = 16'h0000;
  logic [3:0] mii_txd = 4'h0, line_rxd = 4'h0, an_delay = 4'h6;
  logic mgmt_rd_valid, an_started, an_enable, an_restart, eff_duplex_full, eff_rate_100;
  logic low_power, latch_high_status_clear, latch_low_status_clear, mac_rx_dv, mac_rx_er;
  logic mac_crs, mac_col, mac_out_oe_n, line_tx_en, line_tx_er, tx_pair_tristate;
  logic line_rx_enable;
  logic [15:0] mgmt_rd_data;
  logic [3:0] mac_rxd, line_txd;
  int fails = 0;
  int checks_done = 0;
  int n;

  bmc_basic_ctrl #(.COL_ON_CYC(COL_CYC)) DUT (.*);
  bmc_an_partner u_partner (.sys_clk(sys_clk), .resetn(resetn), .an_restart(an_restart),
    .start_delay(an_delay), .an_started(an_started));

  // 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // access and compare tasks, inputs move on the falling edge
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    mgmt_reg_addr = a;
    mgmt_wr_data = d;
    mgmt_wr_en = 1'b1;
    @(negedge sys_clk);
    mgmt_wr_en = 1'b0;
  endtask : wr

  // answer is due one cycle after the request
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge sys_clk);
    mgmt_reg_addr = a;
    mgmt_rd_en = 1'b1;
    @(negedge sys_clk);
    mgmt_rd_en = 1'b0;
    check(mgmt_rd_valid, 16'h0001);
    check(mgmt_rd_data, exp);
  endtask : rd

  task automatic do_reset(input logic [4:0] a);
    resetn = 1'b0;
    phy_addr = a;
    cyc(5);
    resetn = 1'b1;
  endtask : do_reset

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    do_reset(5'h01);
    rd(5'h00, 16'h3000);
    wr(5'h03, 16'hFFFF);
    rd(5'h03, 16'h0000);
    wr(5'h00, 16'h1000);
    rd(5'h00, 16'h1000);
    wr(5'h00, 16'h0100);
    cyc(2);
    check(eff_duplex_full, 16'h0001);
    check(eff_rate_100, 16'h0000);
    check(an_enable, 16'h0000);
    wr(5'h00, 16'h0300);
    check(an_restart, 16'h0000);
    rd(5'h00, 16'h0100);
    wr(5'h00, 16'h1200);
    check(an_restart, 16'h0001);
    rd(5'h00, 16'h1200);
    cyc(12);
    rd(5'h00, 16'h1000);
    check(eff_duplex_full, 16'h0001);
    check(eff_rate_100, 16'h0001);
    // loopback returns transmit nibbles, duplex bit left at half
    mii_txd = 4'hA;
    line_col = 1'b1;
    wr(5'h00, 16'h4000);
    cyc(2);
    check(eff_duplex_full, 16'h0001);
    check(tx_pair_tristate, 16'h0001);
    check(line_rx_enable, 16'h0000);
    check(mac_rxd, 16'h000A);
    check(mac_col, 16'h0000);
    // collision follows the line, not transmit enable, with the test off
    wr(5'h00, 16'h0000);
    line_col = 1'b1;
    mii_tx_en = 1'b1;
    // normal path: line receive to MAC, MAC transmit to line
    {line_rxd, line_rx_dv, line_rx_er, line_crs, mii_tx_er} = 8'h5F;
    cyc(2);
    check(mac_col, 16'h0001);
    check({3'b000, mac_rx_dv, mac_rx_er, mac_crs, line_tx_en, line_tx_er, mac_rxd, line_txd}, 16'h1F5A);
    line_col = 1'b0;
    cyc(2);
    check(mac_col, 16'h0000);
    mii_tx_en = 1'b0;
    // test collision, plain and in loopback
    for (int i = 0; i < 2; i++) begin
      wr(5'h00, (i == 0) ? 16'h0080 : 16'h4080);
      mii_tx_en = 1'b1;
      n = 0;
      while (mac_col !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      check(16'(n <= COL_CYC + 1), 16'h0001);
      mii_tx_en = 1'b0;
      cyc(1);
      check(mac_col, 16'h0000);
    end
    // isolate floats outputs but registers still answer
    wr(5'h00, 16'h0400);
    mii_tx_en = 1'b1;
    cyc(2);
    check(mac_out_oe_n, 16'h0001);
    check(line_tx_en, 16'h0000);
    check({9'h000, mac_rx_dv, mac_rx_er, mac_crs, mac_rxd}, 16'h0000);
    rd(5'h00, 16'h0400);
    mii_tx_en = 1'b0;
    wr(5'h00, 16'h0800);
    check(latch_high_status_clear, 16'h0001);
    check(latch_low_status_clear, 16'h0001);
    cyc(2);
    check(mac_out_oe_n, 16'h0000);
    check(tx_pair_tristate, 16'h0001);
    check({8'h00, mac_rx_dv, mac_rx_er, mac_crs, mac_col, mac_rxd}, 16'h0000);
    rd(5'h00, 16'h0800);
    // a write with the clock enable low must leave the register untouched
    clk_en = 1'b0;
    wr(5'h00, 16'h1000);
    clk_en = 1'b1;
    rd(5'h00, 16'h0800);
    // hardware mode takes both decisions from the pins
    wr(5'h00, 16'h1000);
    strap_mode_select_pin = 1'b0;
    for (int i = 0; i < 2; i++) begin
      autoneg_select_pin = (i == 1);
      duplex_select_pin = (i == 0);
      cyc(2);
      check(an_enable, 16'(i));
      check(eff_duplex_full, 16'(1 - i));
    end
    strap_mode_select_pin = 1'b1;
    do_reset(5'h00);
    rd(5'h00, 16'h3400);
    cyc(2);
    check(mac_out_oe_n, 16'h0001);
    print_verdict();
  end

  // watchdog, the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
endmodule : bmc_basic_ctrl_tb

`default_nettype wire
